// File: design/pod_pkg.sv
package pod_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // opcode bytes
    localparam logic [7:0] OPC_ESCAPE   = 8'h0f;  // two-byte opcode lead-in
    localparam logic [7:0] OPC_GRP0     = 8'h00;  // verify group
    localparam logic [7:0] OPC_GRP1     = 8'h01;  // machine status group
    localparam logic [7:0] OPC_AR_LOAD  = 8'h02;
    localparam logic [7:0] OPC_LIM_LOAD = 8'h03;
    localparam logic [7:0] OPC_PRIV_ADJ = 8'h63;

    // segment override prefix 001 ss 110
    localparam logic [2:0] PFX_HI_BITS  = 3'h1;
    localparam logic [2:0] PFX_LO_BITS  = 3'h6;

    // middle field codes inside the groups
    localparam logic [2:0] MID_MSW_LOAD  = 3'h6;
    localparam logic [2:0] MID_MSW_STORE = 3'h4;
    localparam logic [2:0] MID_RD_VERIFY = 3'h4;
    localparam logic [2:0] MID_WR_VERIFY = 3'h5;

    // operand form field values
    localparam logic [1:0] FORM_NODISP = 2'h0;
    localparam logic [1:0] FORM_DISP8  = 2'h1;
    localparam logic [1:0] FORM_DISP16 = 2'h2;
    localparam logic [1:0] FORM_REG    = 2'h3;

    // operand location field values
    localparam logic [2:0] LOC_BW_SRC = 3'h0;
    localparam logic [2:0] LOC_BW_DST = 3'h1;
    localparam logic [2:0] LOC_FB_SRC = 3'h2;
    localparam logic [2:0] LOC_FB_DST = 3'h3;
    localparam logic [2:0] LOC_SRC    = 3'h4;
    localparam logic [2:0] LOC_DST    = 3'h5;
    localparam logic [2:0] LOC_FB     = 3'h6;  // also direct address under form 00
    localparam logic [2:0] LOC_BW     = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        OP_NONE, OP_MSW_LOAD, OP_MSW_STORE, OP_AR_LOAD,
        OP_LIM_LOAD, OP_PRIV_ADJ, OP_RD_VERIFY, OP_WR_VERIFY
    } pod_op_e;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_GRP0, SEL_GRP1, SEL_AR, SEL_LIM, SEL_PRIV
    } pod_sel_e;

    typedef enum logic [1:0] {
        SEG_EXTRA = 2'h0, SEG_CODE = 2'h1, SEG_STACK = 2'h2, SEG_DATA = 2'h3
    } pod_seg_e;

    // msb is the width select bit, low bits the register code
    typedef enum logic [3:0] {
        R_ACC_LOW  = 4'h0, R_COUNT_LOW  = 4'h1, R_DATA_LOW  = 4'h2, R_BASE_LOW  = 4'h3,
        R_ACC_HIGH = 4'h4, R_COUNT_HIGH = 4'h5, R_DATA_HIGH = 4'h6, R_BASE_HIGH = 4'h7,
        R_ACCUMULATOR_WORD = 4'h8, R_COUNT_WORD = 4'h9, R_DATA_WORD = 4'ha,
        R_BASE_WORD = 4'hb, R_STACK_POINTER = 4'hc, R_FRAME_BASE = 4'hd,
        R_SOURCE_INDEX = 4'he, R_DEST_INDEX = 4'hf
    } pod_reg_e;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ESC    = 3'b001,
        ST_MODRM  = 3'b011,
        ST_DISP_L = 3'b010,
        ST_DISP_H = 3'b110
    } pod_state_e;

    typedef struct packed {
        logic [15:0] base_word;
        logic [15:0] frame_base;
        logic [15:0] source_index;
        logic [15:0] dest_index;
    } pod_gpr_s;

    typedef struct packed {
        pod_op_e     op;
        logic [7:0]  modrm;
        logic        mem_op;
        logic [15:0] disp;
        logic [15:0] ea;
        pod_seg_e    seg;
        pod_reg_e    reg_dst;
        pod_reg_e    rm_reg;
    } pod_dec_s;

endpackage : pod_pkg

// File: design/pod_decoder.sv
// How it works
// - 0F 01 with middle field 110 decodes as machine_status_load.
// - 0F 01 with middle field 100 decodes as machine_status_store.
// - 0F 02 plus addressing byte decodes as access_rights_load.
// - 0F 03 plus addressing byte decodes as segment_limit_load.
// - byte 63 plus addressing byte decodes as privilege_level_adjust.
// - 0F 00 middle 100 is read verify, middle 101 is write verify.
// - form 11 forms no memory address; location field names a register.
// - form 00 means zero displacement and no displacement bytes, except location 110.
// - form 01 takes one byte, sign-extended to 16 bits.
// - form 10 takes two bytes, low first, second is upper half.
// - locations 000-011 add base/frame base to source/dest index.
// - form 00 location 110 is a 16-bit direct address, no register.
// - displacement bytes follow the addressing byte directly.
// - prefix 001ss110 overrides segment: extra, code, stack, data.
// - register field decodes words with width bit 1, bytes with 0.
// - frame-base addressed operands default to the stack segment.
// - string destinations always use extra segment, no override.
module pod_decoder (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // instruction bytes from fetch
    input  wire logic              byte_valid,
    input  wire logic [7:0]        byte_data,
    input  wire logic              width_w,
    input  wire logic              string_dst,
    // address registers from execute
    input  wire pod_pkg::pod_gpr_s gpr,
    // decoded result to address generation
    output logic                   dec_valid,
    output pod_pkg::pod_dec_s      dec
);

    ////////////////////////////////////////////////////////////////////////////
    // register field decode
    function automatic pod_pkg::pod_reg_e reg_of(input logic w, input logic [2:0] code);
        reg_of = pod_pkg::pod_reg_e'({w, code});
    endfunction : reg_of

    // final opcode from the selected group and middle field
    function automatic pod_pkg::pod_op_e op_of(input pod_pkg::pod_sel_e s,
                                               input logic [2:0] mid);
        op_of = pod_pkg::OP_NONE;
        case (s)
            pod_pkg::SEL_GRP1: begin
                if (mid == pod_pkg::MID_MSW_LOAD) op_of = pod_pkg::OP_MSW_LOAD;
                else if (mid == pod_pkg::MID_MSW_STORE) op_of = pod_pkg::OP_MSW_STORE;
            end
            pod_pkg::SEL_GRP0: begin
                if (mid == pod_pkg::MID_RD_VERIFY) op_of = pod_pkg::OP_RD_VERIFY;
                else if (mid == pod_pkg::MID_WR_VERIFY) op_of = pod_pkg::OP_WR_VERIFY;
            end
            pod_pkg::SEL_AR:   op_of = pod_pkg::OP_AR_LOAD;
            pod_pkg::SEL_LIM:  op_of = pod_pkg::OP_LIM_LOAD;
            pod_pkg::SEL_PRIV: op_of = pod_pkg::OP_PRIV_ADJ;
            default:           op_of = pod_pkg::OP_NONE;
        endcase
    endfunction : op_of

    ////////////////////////////////////////////////////////////////////////////
    // state
    pod_pkg::pod_state_e state,   next_state;
    pod_pkg::pod_sel_e   sel,     next_sel;
    logic [7:0]          modrm,   next_modrm;
    logic [15:0]         disp,    next_disp;
    logic                ovr_en,  next_ovr_en;
    pod_pkg::pod_seg_e   ovr_seg, next_ovr_seg;
    logic                next_dec_valid;
    pod_pkg::pod_dec_s   next_dec;
    logic                fin;
    logic [15:0]         base_sum;
    logic                fb_based;

    ////////////////////////////////////////////////////////////////////////////
    // byte sequencing
    always_comb begin
        next_state   = state;
        next_sel     = sel;
        next_modrm   = modrm;
        next_disp    = disp;
        next_ovr_en  = ovr_en;
        next_ovr_seg = ovr_seg;
        fin          = 1'b0;
        if (byte_valid) begin
            case (state)
                pod_pkg::ST_IDLE: begin
                    if (byte_data[7:5] == pod_pkg::PFX_HI_BITS &&
                        byte_data[2:0] == pod_pkg::PFX_LO_BITS) begin
                        next_ovr_en  = 1'b1;
                        next_ovr_seg = pod_pkg::pod_seg_e'(byte_data[4:3]);
                    end else if (byte_data == pod_pkg::OPC_ESCAPE) begin
                        next_state = pod_pkg::ST_ESC;
                    end else if (byte_data == pod_pkg::OPC_PRIV_ADJ) begin
                        next_sel   = pod_pkg::SEL_PRIV;
                        next_state = pod_pkg::ST_MODRM;
                    end else begin
                        next_sel   = pod_pkg::SEL_NONE;
                        next_modrm = {pod_pkg::FORM_REG, 6'h00};
                        next_disp  = 16'h0000;
                        fin        = 1'b1;
                    end
                end
                pod_pkg::ST_ESC: begin
                    next_state = pod_pkg::ST_MODRM;
                    if (byte_data == pod_pkg::OPC_GRP0) next_sel = pod_pkg::SEL_GRP0;
                    else if (byte_data == pod_pkg::OPC_GRP1) next_sel = pod_pkg::SEL_GRP1;
                    else if (byte_data == pod_pkg::OPC_AR_LOAD) next_sel = pod_pkg::SEL_AR;
                    else if (byte_data == pod_pkg::OPC_LIM_LOAD) next_sel = pod_pkg::SEL_LIM;
                    else begin
                        next_sel   = pod_pkg::SEL_NONE;
                        next_modrm = {pod_pkg::FORM_REG, 6'h00};
                        next_disp  = 16'h0000;
                        next_state = pod_pkg::ST_IDLE;
                        fin        = 1'b1;
                    end
                end
                pod_pkg::ST_MODRM: begin
                    next_modrm = byte_data;
                    next_disp  = 16'h0000;
                    if (byte_data[7:6] == pod_pkg::FORM_REG) begin
                        next_state = pod_pkg::ST_IDLE;
                        fin        = 1'b1;
                    end else if (byte_data[7:6] == pod_pkg::FORM_NODISP &&
                                 byte_data[2:0] != pod_pkg::LOC_FB) begin
                        next_state = pod_pkg::ST_IDLE;
                        fin        = 1'b1;
                    end else begin
                        next_state = pod_pkg::ST_DISP_L;
                    end
                end
                pod_pkg::ST_DISP_L: begin
                    if (modrm[7:6] == pod_pkg::FORM_DISP8) begin
                        next_disp  = {{8{byte_data[7]}}, byte_data};
                        next_state = pod_pkg::ST_IDLE;
                        fin        = 1'b1;
                    end else begin
                        next_disp  = {8'h00, byte_data};
                        next_state = pod_pkg::ST_DISP_H;
                    end
                end
                pod_pkg::ST_DISP_H: begin
                    next_disp  = {byte_data, disp[7:0]};
                    next_state = pod_pkg::ST_IDLE;
                    fin        = 1'b1;
                end
                default: next_state = pod_pkg::ST_IDLE;
            endcase
            if (fin) begin
                next_ovr_en = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address and segment formation
    always_comb begin
        base_sum = 16'h0000;
        fb_based = 1'b0;
        case (next_modrm[2:0])
            pod_pkg::LOC_BW_SRC: base_sum = gpr.base_word + gpr.source_index;
            pod_pkg::LOC_BW_DST: base_sum = gpr.base_word + gpr.dest_index;
            pod_pkg::LOC_FB_SRC: base_sum = gpr.frame_base + gpr.source_index;
            pod_pkg::LOC_FB_DST: base_sum = gpr.frame_base + gpr.dest_index;
            pod_pkg::LOC_SRC:    base_sum = gpr.source_index;
            pod_pkg::LOC_DST:    base_sum = gpr.dest_index;
            pod_pkg::LOC_FB:     base_sum = gpr.frame_base;
            default:             base_sum = gpr.base_word;
        endcase
        if (next_modrm[7:6] == pod_pkg::FORM_NODISP && next_modrm[2:0] == pod_pkg::LOC_FB) begin
            base_sum = 16'h0000;
        end
        if (next_modrm[2:0] == pod_pkg::LOC_FB_SRC || next_modrm[2:0] == pod_pkg::LOC_FB_DST ||
            (next_modrm[2:0] == pod_pkg::LOC_FB && next_modrm[7:6] != pod_pkg::FORM_NODISP)) begin
            fb_based = 1'b1;
        end
        next_dec_valid  = fin;
        next_dec        = dec;
        if (fin) begin
            next_dec.op      = op_of(next_sel, next_modrm[5:3]);
            next_dec.modrm   = next_modrm;
            next_dec.mem_op  = (next_modrm[7:6] != pod_pkg::FORM_REG) &&
                               (next_sel != pod_pkg::SEL_NONE);
            next_dec.disp    = next_disp;
            next_dec.ea      = next_dec.mem_op ? base_sum + next_disp : 16'h0000;
            next_dec.reg_dst = reg_of(width_w, next_modrm[5:3]);
            next_dec.rm_reg  = reg_of(width_w, next_modrm[2:0]);
            if (string_dst) next_dec.seg = pod_pkg::SEG_EXTRA;
            else if (ovr_en) next_dec.seg = ovr_seg;
            else if (fb_based) next_dec.seg = pod_pkg::SEG_STACK;
            else next_dec.seg = pod_pkg::SEG_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state     <= pod_pkg::ST_IDLE;
            sel       <= pod_pkg::SEL_NONE;
            modrm     <= 8'h00;
            disp      <= 16'h0000;
            ovr_en    <= 1'b0;
            ovr_seg   <= pod_pkg::SEG_DATA;
            dec_valid <= 1'b0;
            dec       <= '0;
        end else begin
            state     <= next_state;
            sel       <= next_sel;
            modrm     <= next_modrm;
            disp      <= next_disp;
            ovr_en    <= next_ovr_en;
            ovr_seg   <= next_ovr_seg;
            dec_valid <= next_dec_valid;
            dec       <= next_dec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_msw_load;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == pod_pkg::ST_MODRM && byte_valid && sel == pod_pkg::SEL_GRP1 &&
         byte_data[5:3] == 3'h6 && byte_data[7:6] == 2'h3)
        |=> dec_valid && dec.op == pod_pkg::OP_MSW_LOAD;
    endproperty
    a_msw_load: assert property (p_msw_load) else $error("load status not decoded");

    property p_msw_store;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == pod_pkg::ST_MODRM && byte_valid && sel == pod_pkg::SEL_GRP1 &&
         byte_data[5:3] == 3'h4 && byte_data[7:6] == 2'h3)
        |=> dec_valid && dec.op == pod_pkg::OP_MSW_STORE && !dec.mem_op;
    endproperty
    a_msw_store: assert property (p_msw_store) else $error("store status not decoded");

    property p_esc_sel;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == pod_pkg::ST_ESC && byte_valid && byte_data == 8'h02)
        |=> state == pod_pkg::ST_MODRM && sel == pod_pkg::SEL_AR;
    endproperty
    a_esc_sel: assert property (p_esc_sel) else $error("rights load not selected");

    sequence s_priv_op;
        state == pod_pkg::ST_IDLE && byte_valid && byte_data == 8'h63;
    endsequence
    property p_priv;
        @(posedge sys_clk) disable iff (sys_rst)
        s_priv_op ##1 (byte_valid && byte_data[7:6] == 2'h3)
        |=> dec_valid && dec.op == pod_pkg::OP_PRIV_ADJ;
    endproperty
    a_priv: assert property (p_priv) else $error("privilege adjust not decoded");

    property p_reg_form;
        @(posedge sys_clk) disable iff (sys_rst)
        dec_valid && dec.modrm[7:6] == 2'h3 |-> !dec.mem_op && dec.ea == 16'h0000;
    endproperty
    a_reg_form: assert property (p_reg_form) else $error("register form made address");

    property p_no_disp;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == pod_pkg::ST_MODRM && byte_valid && byte_data[7:6] == 2'h0 &&
         byte_data[2:0] != 3'h6) |=> dec_valid && dec.disp == 16'h0000;
    endproperty
    a_no_disp: assert property (p_no_disp) else $error("form 00 carried displacement");

    property p_disp8;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == pod_pkg::ST_DISP_L && byte_valid && modrm[7:6] == 2'h1)
        |=> dec_valid && dec.disp == {{8{$past(byte_data[7])}}, $past(byte_data)};
    endproperty
    a_disp8: assert property (p_disp8) else $error("short displacement wrong");

    sequence s_two_disp;
        state == pod_pkg::ST_DISP_L && byte_valid && modrm[7:6] != 2'h1;
    endsequence
    sequence s_disp_hi;
        state == pod_pkg::ST_DISP_H && byte_valid;
    endsequence
    // low byte kept while the high byte is awaited
    property p_disp_low;
        @(posedge sys_clk) disable iff (sys_rst)
        s_two_disp |=> state == pod_pkg::ST_DISP_H && disp[7:0] == $past(byte_data);
    endproperty
    a_disp_low: assert property (p_disp_low) else $error("low displacement byte lost");

    property p_disp16;
        @(posedge sys_clk) disable iff (sys_rst)
        s_disp_hi |=> dec_valid && dec.disp == {$past(byte_data), $past(disp[7:0])};
    endproperty
    a_disp16: assert property (p_disp16) else $error("long displacement wrong");

    property p_direct;
        @(posedge sys_clk) disable iff (sys_rst)
        dec_valid && dec.mem_op && dec.modrm[7:6] == 2'h0 && dec.modrm[2:0] == 3'h6
        |-> dec.ea == dec.disp;
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");

    property p_str_seg;
        @(posedge sys_clk) disable iff (sys_rst)
        fin && string_dst |=> dec.seg == pod_pkg::SEG_EXTRA;
    endproperty
    a_str_seg: assert property (p_str_seg) else $error("string target segment wrong");

    property p_stack_seg;
        @(posedge sys_clk) disable iff (sys_rst)
        fin && !string_dst && !ovr_en && fb_based |=> dec.seg == pod_pkg::SEG_STACK;
    endproperty
    a_stack_seg: assert property (p_stack_seg) else $error("frame base not stack");

endmodule : pod_decoder

// File: sim/pod_fetch_model.sv
module pod_fetch_model (
    // clock
    input  wire logic       sys_clk,
    // byte stream to the decoder
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    // bench-only marker of an instruction's last byte
    output logic            fin_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle stream at time zero
    initial begin
        byte_valid = 1'b0;
        byte_data  = 8'h5a;
        fin_byte   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // gap cycles: a released data line never keeps its last value
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            byte_valid <= 1'b0;
            fin_byte   <= 1'b0;
            byte_data  <= ~byte_data;
        end
    endtask : idle

    // one byte, held for exactly one high cycle
    task automatic send_byte(input logic [7:0] b, input int gap, input logic last);
        idle(gap);
        @(posedge sys_clk);
        byte_valid <= 1'b1;
        byte_data  <= b;
        fin_byte   <= last;
    endtask : send_byte
endmodule : pod_fetch_model

// File: sim/protect_op_and_ea_decoder_bench.sv
module protect_op_and_ea_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic              sys_clk    = 1'b0;
    logic              sys_rst    = 1'b1;
    logic              width_w    = 1'b0;
    logic              string_dst = 1'b0;
    pod_pkg::pod_gpr_s gpr        = '0;
    logic              byte_valid;
    logic [7:0]        byte_data;
    logic              fin_byte;
    logic              dec_valid;
    pod_pkg::pod_dec_s dec;
    int                err_total  = 0;
    int                cmp_count  = 0;
    int                seed       = 32'h0a1b_e40d;
    int                cyc        = 0;
    int                fin_q[$];
    int                lvl_q[$];
    pod_pkg::pod_dec_s exp_q[$];
    logic [7:0]        bytes[$];

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    pod_fetch_model pod_fetch_model_inst (
        .sys_clk    (sys_clk),
        .byte_valid (byte_valid),
        .byte_data  (byte_data),
        .fin_byte   (fin_byte)
    );

    pod_decoder pod_decoder_inst (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .byte_valid (byte_valid),
        .byte_data  (byte_data),
        .width_w    (width_w),
        .string_dst (string_dst),
        .gpr        (gpr),
        .dec_valid  (dec_valid),
        .dec        (dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    // verdict and end of run
    task automatic finish_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    // reference model: builds the byte list and the expected result
    task automatic run_instr(input int kind, input int npfx, input logic str, input int gap);
        pod_pkg::pod_dec_s e;
        pod_pkg::pod_gpr_s g;
        logic [7:0]        m;
        logic [7:0]        d0;
        logic [7:0]        d1;
        logic [7:0]        sec;
        logic [1:0]        ss;
        logic [15:0]       base;
        logic              w;
        logic              ovr;
        logic              direct;
        int                lvl;
        m = 8'($random(seed));
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        w = 1'($random(seed));
        g = {$random(seed), $random(seed)};
        e = '0;
        ss = 2'h0;
        ovr = 1'b0;
        lvl = 2;
        sec = pod_pkg::OPC_GRP1;
        bytes.delete();
        for (int i = 0; i < npfx; i++) begin
            ss = 2'($random(seed));
            ovr = 1'b1;
            bytes.push_back({pod_pkg::PFX_HI_BITS, ss, pod_pkg::PFX_LO_BITS});
        end
        case (kind)
            0: begin m[5:3] = pod_pkg::MID_MSW_LOAD; e.op = pod_pkg::OP_MSW_LOAD; end
            1: begin m[5:3] = pod_pkg::MID_MSW_STORE; e.op = pod_pkg::OP_MSW_STORE; end
            2: begin sec = pod_pkg::OPC_AR_LOAD; e.op = pod_pkg::OP_AR_LOAD; end
            3: begin sec = pod_pkg::OPC_LIM_LOAD; e.op = pod_pkg::OP_LIM_LOAD; end
            4: e.op = pod_pkg::OP_PRIV_ADJ;
            5: begin sec = 8'h00; m[5:3] = pod_pkg::MID_RD_VERIFY; e.op = pod_pkg::OP_RD_VERIFY; end
            6: begin sec = 8'h00; m[5:3] = pod_pkg::MID_WR_VERIFY; e.op = pod_pkg::OP_WR_VERIFY; end
            9: begin m[5:3] = 3'h2; lvl = 1; end
            default: lvl = 0;
        endcase
        if (kind == 7) begin
            bytes.push_back(8'h90);
        end else if (kind == 8) begin
            bytes.push_back(pod_pkg::OPC_ESCAPE);
            bytes.push_back(8'h07);
        end else begin
            if (kind == 4) begin
                bytes.push_back(pod_pkg::OPC_PRIV_ADJ);
            end else begin
                bytes.push_back(pod_pkg::OPC_ESCAPE);
                bytes.push_back(sec);
            end
            bytes.push_back(m); // displacement comes right after this byte
            direct = (m[7:6] == pod_pkg::FORM_NODISP) && (m[2:0] == pod_pkg::LOC_FB);
            e.modrm = m;
            e.mem_op = (m[7:6] != pod_pkg::FORM_REG);
            e.reg_dst = pod_pkg::pod_reg_e'({w, m[5:3]});
            e.rm_reg = pod_pkg::pod_reg_e'({w, m[2:0]});
            if (m[7:6] == pod_pkg::FORM_DISP8) begin
                bytes.push_back(d0);
                e.disp = {{8{d0[7]}}, d0};
            end else if (m[7:6] == pod_pkg::FORM_DISP16 || direct) begin
                bytes.push_back(d0);
                bytes.push_back(d1);
                e.disp = {d1, d0};
            end
            case (m[2:0])
                3'h0: base = g.base_word + g.source_index;
                3'h1: base = g.base_word + g.dest_index;
                3'h2: base = g.frame_base + g.source_index;
                3'h3: base = g.frame_base + g.dest_index;
                3'h4: base = g.source_index;
                3'h5: base = g.dest_index;
                3'h6: base = direct ? 16'h0000 : g.frame_base;
                default: base = g.base_word;
            endcase
            e.ea = base + e.disp;
            if (str) begin
                e.seg = pod_pkg::SEG_EXTRA;
            end else if (ovr) begin
                e.seg = pod_pkg::pod_seg_e'(ss);
            end else if ((m[2:1] == 2'h1 || m[2:0] == pod_pkg::LOC_FB) && !direct) begin
                e.seg = pod_pkg::SEG_STACK;
            end else begin
                e.seg = pod_pkg::SEG_DATA;
            end
            if (lvl == 2 && !e.mem_op) begin
                lvl = 1;
            end
        end
        for (int i = 0; i < bytes.size(); i++) begin
            pod_fetch_model_inst.send_byte(bytes[i], (i == 0) ? gap : int'($random(seed) & 1),
                                           i == bytes.size() - 1);
            if (i == 0) begin
                width_w <= w;
                string_dst <= str;
                gpr <= g;
            end
        end
        exp_q.push_back(e);
        lvl_q.push_back(lvl);
    endtask : run_instr

    ////////////////////////////////////////////////////////////////////////////
    // monitor: every result against the model, one cycle after the last byte
    always @(posedge sys_clk) begin : mon
        pod_pkg::pod_dec_s e;
        int                l;
        if (dec_valid === 1'b1) begin
            if (exp_q.size() == 0 || fin_q.size() == 0) begin
                check("unexpected result", 16'h0001, 16'h0000);
            end else begin
                e = exp_q.pop_front();
                l = lvl_q.pop_front();
                check("latency", 16'(cyc - fin_q.pop_front()), 16'h0001);
                check("op", 16'(dec.op), 16'(e.op));
                check("mem_op", 16'(dec.mem_op), 16'(e.mem_op));
                if (l > 0) begin
                    check("modrm", 16'(dec.modrm), 16'(e.modrm));
                    check("reg_dst", 16'(dec.reg_dst), 16'(e.reg_dst));
                    check("rm_reg", 16'(dec.rm_reg), 16'(e.rm_reg));
                end
                if (l > 1) begin
                    check("disp", dec.disp, e.disp);
                    check("ea", dec.ea, e.ea);
                    check("seg", 16'(dec.seg), 16'(e.seg));
                end
            end
        end
        if (byte_valid === 1'b1 && fin_byte === 1'b1 && sys_rst === 1'b0) begin
            fin_q.push_back(cyc);
        end
        cyc++;
    end

    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1 check("reset result", 16'(dec === '0), 16'h0001);
        for (int k = 0; k < 10; k++) begin
            run_instr(k, 0, 1'b0, 0);
        end
        for (int n = 0; n < 300; n++) begin
            run_instr((($random(seed) & 32'h7fff_ffff) % 10), ($random(seed) & 3) % 3,
                      ($random(seed) & 3) == 0, $random(seed) & 3);
        end
        pod_fetch_model_inst.send_byte(8'h26, 0, 1'b0);
        pod_fetch_model_inst.idle(3);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1 check("reset result", 16'(dec === '0), 16'h0001);
        run_instr(5, 0, 1'b0, 0);
        pod_fetch_model_inst.idle(4);
        check("pending results", 16'(exp_q.size()), 16'h0000);
        finish_test();
    end

    // watchdog against a hung stream
    initial begin
        #200_000;
        err_total++;
        finish_test();
    end
endmodule : protect_op_and_ea_decoder_bench
